// *** src/srwp_pkg.sv ***
package srwp_pkg;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_WR_SR1 = 8'h01;
   localparam logic [7:0] CMD_WR_SR2 = 8'h31;
   localparam logic [7:0] CMD_WR_SR3 = 8'h11;
   localparam logic [7:0] CMD_WR_INDEXED = 8'h71;
   localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
   localparam logic [7:0] CMD_RD_SR1 = 8'h05;
   localparam logic [7:0] CMD_RD_SR2 = 8'h35;
   localparam logic [7:0] CMD_RD_SR3 = 8'h15;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h99;

   // ****************************************
   // Register indices for the indexed write
   // ****************************************
   localparam logic [7:0] REG_IDX_SR1 = 8'h01;
   localparam logic [7:0] REG_IDX_SR2 = 8'h02;
   localparam logic [7:0] REG_IDX_SR3 = 8'h03;

   // ****************************************
   // Field positions, masks, reset values
   // ****************************************
   localparam int SR1_PROT_LO_BIT = 7;
   localparam int SR1_WEL_BIT = 1;
   localparam int SR2_QE_BIT = 1;
   localparam int SR2_PROT_HI_BIT = 0;
   localparam int SR3_PIN_SEL_BIT = 7;
   localparam logic [7:0] SR1_WR_MASK = 8'hFC;
   localparam logic [7:0] SR2_WR_MASK = 8'h03;
   localparam logic [7:0] SR3_WR_MASK = 8'h80;
   localparam logic [7:0] SR1_RESET = 8'h80;
   localparam logic [7:0] SR2_RESET = 8'h01;
   localparam logic [7:0] SR3_RESET = 8'h00;
   localparam logic [4:0] PINS_IDLE = 5'h13; // Idle pins: csB, wpB, holdRstB high

   // ****************************************
   // Counts
   // ****************************************
   localparam logic [2:0] BYTES_CMD_ONLY = 3'h1;
   localparam logic [2:0] BYTES_WR = 3'h2;
   localparam logic [2:0] BYTES_WR_INDEXED = 3'h3;
   localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] RELOAD_WAIT = 2'h3;

   // Protect pair encodings, {protect_bit_high, protect_bit_low}
   localparam logic [1:0] PROT_SW = 2'h0;
   localparam logic [1:0] PROT_HW = 2'h1;
   localparam logic [1:0] PROT_LOCKDOWN = 2'h2;
   localparam logic [1:0] PROT_STICKY = 2'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic csB;
      logic sck;
      logic mosi;
      logic wpB;
      logic holdRstB;
   } srwp_pins_t;

   typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_HOLD} srwp_spi_state_t;

   // ****************************************
   // Functions
   // ****************************************
   // Write allowed by protect pair, pin and latch; lock input unused
   function automatic logic writeAllowed(input logic [1:0] prot, input logic lock,
                                         input logic wpHigh, input logic write_enable_latch);
      logic ok;
      case (prot)
         PROT_SW: ok = 1'b1;
         PROT_HW: ok = wpHigh;
         default: ok = 1'b0;
      endcase
      writeAllowed = ok & write_enable_latch;
   endfunction : writeAllowed

   // Volatile pair loaded from non-volatile copy
   function automatic logic [1:0] reloadMap(input logic [1:0] nv, input logic lock);
      logic [1:0] v;
      case (nv)
         PROT_SW: v = PROT_SW;
         PROT_HW: v = PROT_HW;
         PROT_LOCKDOWN: v = PROT_SW;
         default: v = lock ? PROT_STICKY : PROT_HW;
      endcase
      reloadMap = v;
   endfunction : reloadMap

   // Replace writable bits only
   function automatic logic [7:0] maskedWrite(input logic [7:0] old, input logic [7:0] val,
                                              input logic [7:0] mask);
      maskedWrite = (old & ~mask) | (val & mask);
   endfunction : maskedWrite

endpackage : srwp_pkg

// *** src/srwp_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module srwp_sync
   import srwp_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;

   // First stage feeds only the second; reset to idle level, no false edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         stage1_q <= RST_VAL;
         stage2_q <= RST_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;
endmodule : srwp_sync

// *** src/srwp_reload.sv ***
`timescale 1ns/10ps
// Loads the volatile protect pair after any reset
module srwp_reload
   import srwp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic reloadReq,
   input wire logic [1:0] nvProtect,
   input wire logic nvLock,
   output logic loadPulse,
   output logic [1:0] loadVal
);
   logic [1:0] waitCnt_q;
   logic [1:0] waitCnt_d;
   logic loadPulse_q;
   logic loadPulse_d;
   logic [1:0] loadVal_q;
   logic [1:0] loadVal_d;

   // Wait out the synchronisers, then map the copy
   always_comb begin
      waitCnt_d = waitCnt_q;
      loadPulse_d = 1'b0;
      loadVal_d = loadVal_q;
      if (reloadReq) begin
         waitCnt_d = RELOAD_WAIT;
      end else if (waitCnt_q != 2'h0) begin
         waitCnt_d = 2'(waitCnt_q - 2'h1);
         if (waitCnt_q == 2'h1) begin
            loadPulse_d = 1'b1;
            loadVal_d = reloadMap(nvProtect, nvLock);
         end
      end
   end

   // State registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt_q <= RELOAD_WAIT;
         loadPulse_q <= 1'b0;
         loadVal_q <= PROT_STICKY;
      end else begin
         waitCnt_q <= waitCnt_d;
         loadPulse_q <= loadPulse_d;
         loadVal_q <= loadVal_d;
      end
   end

   assign loadPulse = loadPulse_q;
   assign loadVal = loadVal_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence sArm;
      waitCnt_q == 2'h1 && !reloadReq;
   endsequence
   a_reload_zero_zero: assert property (sArm and nvProtect == 2'h0 |=> loadPulse && loadVal == 2'h0)
      else $error("copy 00 did not load 00");
   a_reload_zero_one: assert property (sArm and nvProtect == 2'h1 |=> loadPulse && loadVal == 2'h1)
      else $error("copy 01 did not load 01");
   a_reload_lockdown_release: assert property (sArm and nvProtect == 2'h2 |=> loadVal == 2'h0)
      else $error("copy 10 did not release to 00");
   a_reload_sticky_unlocked: assert property (sArm and nvProtect == 2'h3 && !nvLock |=> loadVal == 2'h1)
      else $error("copy 11 unlocked did not load 01");
   a_reload_sticky_locked: assert property (sArm and nvProtect == 2'h3 && nvLock |=> loadVal == 2'h3)
      else $error("copy 11 locked did not keep 11");
endmodule : srwp_reload

// *** src/srwp_core.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Pair 00: write-status accepted when write-enable latch set; protect pin ignored.
// - Pair 01 with protect pin low and quad enable clear: every status write refused.
// - Pair 01 with protect pin high: write-status accepted with latch set.
// - Pair 10: all status writes blocked until next reset of any kind.
// - Pair 11, lock clear: status writes blocked until next reset.
// - Pair 11, lock set: status writes refused permanently.
// - Reset with copy 00 loads volatile pair 00.
// - Reset with copy 01 loads volatile pair 01.
// - Reset with copy 10 loads pair 00, releasing lockdown.
// - Reset with copy 11 and lock clear loads pair 01.
// - Reset with copy 11 and lock set keeps pair 11.
// - Register three bit 7 picks shared pin role: 0 hold, 1 reset.
// - Pin role applies only while quad enable is clear; else neither.
module srwp_core
   import srwp_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire srwp_pins_t pins,
   input wire logic [1:0] nvProtect,
   input wire logic nvLock,
   output logic miso,
   output logic misoOe_b,
   output logic holdActive,
   output logic pinReset,
   output logic [7:0] statusOne,
   output logic [7:0] statusTwo,
   output logic [7:0] statusThree
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   srwp_pins_t pinsS;
   logic [2:0] nvS;
   logic [1:0] nvProtectS;
   logic nvLockS;

   srwp_sync #(.W($bits(srwp_pins_t)), .RST_VAL(PINS_IDLE)) u_pin_sync (
      .clock(clock),
      .rst_b(rst_b),
      .asyncIn(pins),
      .syncOut(pinsS)
   );

   srwp_sync #(.W(3)) u_nv_sync (
      .clock(clock),
      .rst_b(rst_b),
      .asyncIn({nvLock, nvProtect}),
      .syncOut(nvS)
   );

   assign nvProtectS = nvS[1:0];
   assign nvLockS = nvS[2];

   // ****************************************
   // Declarations
   // ****************************************
   srwp_spi_state_t state_q;
   srwp_spi_state_t state_d;
   logic sckPrev_q;
   logic sckPrev_d;
   logic csPrev_q;
   logic csPrev_d;
   logic [2:0] bitCnt_q;
   logic [2:0] bitCnt_d;
   logic [2:0] byteCnt_q;
   logic [2:0] byteCnt_d;
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic [7:0] byteOne_q;
   logic [7:0] byteOne_d;
   logic [7:0] byteTwo_q;
   logic [7:0] byteTwo_d;
   logic [7:0] misoShift_q;
   logic [7:0] misoShift_d;
   logic miso_q;
   logic miso_d;
   logic misoOeB_q;
   logic misoOeB_d;
   logic [7:0] sr1_q;
   logic [7:0] sr1_d;
   logic [7:0] sr2_q;
   logic [7:0] sr2_d;
   logic [7:0] sr3_q;
   logic [7:0] sr3_d;
   logic sckRise;
   logic sckFall;
   logic csRise;
   logic quadOn;
   logic welQ;
   logic wpEff;
   logic [1:0] prot;
   logic isWrCmd;
   logic isRdCmd;
   logic [2:0] wrBytes;
   logic commitWr;
   logic allowed;
   logic [7:0] wrIdx;
   logic [7:0] wrData;
   logic exactCmd;
   logic swReset;
   logic loadPulse;
   logic [1:0] loadVal;

   // ****************************************
   // Decode of pins and command
   // ****************************************
   // Edges and pin roles
   assign sckRise = pinsS.sck & ~sckPrev_q;
   assign sckFall = ~pinsS.sck & sckPrev_q;
   assign csRise = pinsS.csB & ~csPrev_q;
   assign quadOn = sr2_q[SR2_QE_BIT];
   assign holdActive = ~quadOn & ~sr3_q[SR3_PIN_SEL_BIT] & ~pinsS.holdRstB & ~pinsS.csB;
   assign pinReset = ~quadOn & sr3_q[SR3_PIN_SEL_BIT] & ~pinsS.holdRstB;
   assign wpEff = quadOn | pinsS.wpB;
   assign prot = {sr2_q[SR2_PROT_HI_BIT], sr1_q[SR1_PROT_LO_BIT]};
   assign welQ = sr1_q[SR1_WEL_BIT];

   // Write command decode
   assign isWrCmd = (cmd_q == CMD_WR_SR1) || (cmd_q == CMD_WR_SR2) || (cmd_q == CMD_WR_SR3) ||
                    (cmd_q == CMD_WR_INDEXED);
   assign isRdCmd = (cmd_q == CMD_RD_SR1) || (cmd_q == CMD_RD_SR2) || (cmd_q == CMD_RD_SR3);
   assign wrBytes = (cmd_q == CMD_WR_INDEXED) ? BYTES_WR_INDEXED : BYTES_WR;
   assign wrData = (cmd_q == CMD_WR_INDEXED) ? byteTwo_q : byteOne_q;
   assign exactCmd = csRise && !pinReset && bitCnt_q == 3'h0;
   assign commitWr = exactCmd && isWrCmd && byteCnt_q == wrBytes;
   assign swReset = exactCmd && cmd_q == CMD_SOFT_RESET && byteCnt_q == BYTES_CMD_ONLY;
   assign allowed = writeAllowed(prot, nvLockS, wpEff, welQ);

   // Target register of a write
   always_comb begin
      if (cmd_q == CMD_WR_SR1) begin
         wrIdx = REG_IDX_SR1;
      end else if (cmd_q == CMD_WR_SR2) begin
         wrIdx = REG_IDX_SR2;
      end else if (cmd_q == CMD_WR_SR3) begin
         wrIdx = REG_IDX_SR3;
      end else begin
         wrIdx = byteOne_q;
      end
   end

   // ****************************************
   // Reload of volatile protect pair
   // ****************************************
   srwp_reload u_reload (
      .clock(clock),
      .rst_b(rst_b),
      .reloadReq(pinReset | swReset),
      .nvProtect(nvProtectS),
      .nvLock(nvLockS),
      .loadPulse(loadPulse),
      .loadVal(loadVal)
   );

   // ****************************************
   // Serial shifter
   // ****************************************
   // Next values of the shifter
   always_comb begin
      state_d = state_q;
      sckPrev_d = pinsS.sck;
      csPrev_d = pinsS.csB;
      bitCnt_d = bitCnt_q;
      byteCnt_d = byteCnt_q;
      shift_d = shift_q;
      cmd_d = cmd_q;
      byteOne_d = byteOne_q;
      byteTwo_d = byteTwo_q;
      misoShift_d = misoShift_q;
      miso_d = miso_q;
      misoOeB_d = misoOeB_q;
      case (state_q)
         SPI_IDLE: begin
            bitCnt_d = 3'h0;
            byteCnt_d = 3'h0;
            misoOeB_d = 1'b1;
            if (!pinsS.csB && !pinReset) begin
               state_d = SPI_SHIFT;
            end
         end
         SPI_SHIFT: begin
            if (pinsS.csB || pinReset) begin
               state_d = SPI_IDLE;
            end else if (holdActive) begin
               state_d = SPI_HOLD;
            end else if (sckRise) begin
               shift_d = {shift_q[6:0], pinsS.mosi};
               bitCnt_d = 3'(bitCnt_q + 3'h1);
               if (bitCnt_q == LAST_BIT) begin
                  byteCnt_d = (byteCnt_q == BYTE_CNT_MAX) ? BYTE_CNT_MAX : 3'(byteCnt_q + 3'h1);
                  if (byteCnt_q == 3'h0) begin
                     cmd_d = {shift_q[6:0], pinsS.mosi};
                  end else if (byteCnt_q == 3'h1) begin
                     byteOne_d = {shift_q[6:0], pinsS.mosi};
                  end else if (byteCnt_q == 3'h2) begin
                     byteTwo_d = {shift_q[6:0], pinsS.mosi};
                  end
                  // Reload read data each byte
                  case ((byteCnt_q == 3'h0) ? {shift_q[6:0], pinsS.mosi} : cmd_q)
                     CMD_RD_SR1: misoShift_d = sr1_q;
                     CMD_RD_SR2: misoShift_d = sr2_q;
                     CMD_RD_SR3: misoShift_d = sr3_q;
                     default: misoShift_d = 8'h00;
                  endcase
               end
            end else if (sckFall && byteCnt_q != 3'h0 && isRdCmd) begin
               miso_d = misoShift_q[7];
               misoShift_d = {misoShift_q[6:0], 1'b0};
               misoOeB_d = 1'b0;
            end
         end
         SPI_HOLD: begin
            misoOeB_d = 1'b1;
            if (pinsS.csB || pinReset) begin
               state_d = SPI_IDLE;
            end else if (!holdActive) begin
               state_d = SPI_SHIFT;
            end
         end
         default: begin
            state_d = SPI_IDLE;
         end
      endcase
   end

   // Shifter registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= SPI_IDLE;
         sckPrev_q <= 1'b0;
         csPrev_q <= 1'b1;
         bitCnt_q <= 3'h0;
         byteCnt_q <= 3'h0;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
         byteOne_q <= 8'h00;
         byteTwo_q <= 8'h00;
         misoShift_q <= 8'h00;
         miso_q <= 1'b0;
         misoOeB_q <= 1'b1;
      end else begin
         state_q <= state_d;
         sckPrev_q <= sckPrev_d;
         csPrev_q <= csPrev_d;
         bitCnt_q <= bitCnt_d;
         byteCnt_q <= byteCnt_d;
         shift_q <= shift_d;
         cmd_q <= cmd_d;
         byteOne_q <= byteOne_d;
         byteTwo_q <= byteTwo_d;
         misoShift_q <= misoShift_d;
         miso_q <= miso_d;
         misoOeB_q <= misoOeB_d;
      end
   end

   // ****************************************
   // Status registers
   // ****************************************
   // Next values of the status registers
   always_comb begin
      sr1_d = sr1_q;
      sr2_d = sr2_q;
      sr3_d = sr3_q;
      if (loadPulse) begin
         sr1_d[SR1_PROT_LO_BIT] = loadVal[0];
         sr2_d[SR2_PROT_HI_BIT] = loadVal[1];
         sr1_d[SR1_WEL_BIT] = 1'b0;
      end else if (pinReset) begin
         sr1_d[SR1_WEL_BIT] = 1'b0;
      end else if (commitWr && allowed) begin
         if (wrIdx == REG_IDX_SR1) begin
            sr1_d = maskedWrite(sr1_q, wrData, SR1_WR_MASK);
         end else if (wrIdx == REG_IDX_SR2) begin
            sr2_d = maskedWrite(sr2_q, wrData, SR2_WR_MASK);
         end else if (wrIdx == REG_IDX_SR3) begin
            sr3_d = maskedWrite(sr3_q, wrData, SR3_WR_MASK);
         end
         sr1_d[SR1_WEL_BIT] = 1'b0;
      end else if (exactCmd && byteCnt_q == BYTES_CMD_ONLY && cmd_q == CMD_WR_ENABLE) begin
         sr1_d[SR1_WEL_BIT] = 1'b1;
      end else if (exactCmd && byteCnt_q == BYTES_CMD_ONLY && cmd_q == CMD_WR_DISABLE) begin
         sr1_d[SR1_WEL_BIT] = 1'b0;
      end
      // Refused writes fall through untouched
   end

   // Status registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sr1_q <= SR1_RESET;
         sr2_q <= SR2_RESET;
         sr3_q <= SR3_RESET;
      end else begin
         sr1_q <= sr1_d;
         sr2_q <= sr2_d;
         sr3_q <= sr3_d;
      end
   end

   assign miso = miso_q;
   assign misoOe_b = misoOeB_q;
   assign statusOne = sr1_q;
   assign statusTwo = sr2_q;
   assign statusThree = sr3_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   sequence sRegsHeld;
      $stable(sr1_q) && $stable(sr2_q) && $stable(sr3_q);
   endsequence
   sequence sWrite;
      commitWr && !loadPulse;
   endsequence
   a_sw_prot_accept: assert property (sWrite and prot == 2'h0 && welQ |=> !welQ)
      else $error("unprotected write not taken");
   a_hw_prot_refuse: assert property (sWrite and prot == 2'h1 && !wpEff |=> sRegsHeld ##1 sRegsHeld)
      else $error("write taken with protect pin low");
   a_hw_unprot_accept: assert property (sWrite and prot == 2'h1 && wpEff && welQ |=> !welQ)
      else $error("write refused with protect pin high");
   a_lockdown_refuse: assert property (sWrite and prot == 2'h2 |=> sRegsHeld)
      else $error("write taken during lockdown");
   a_sticky_refuse: assert property (sWrite and prot == 2'h3 && !nvLockS |=> sRegsHeld)
      else $error("write taken with pair 11 unlocked");
   a_otp_refuse: assert property (sWrite and prot == 2'h3 && nvLockS |=> sRegsHeld and welQ == $past(welQ))
      else $error("write taken with permanent lock");
   a_pin_role_select: assert property (holdActive |-> !sr3_q[7] and !pinReset)
      else $error("hold active while reset role chosen");
   a_quad_disables_pin: assert property (sr2_q[1] |-> !holdActive && !pinReset)
      else $error("pin role active in quad mode");
   a_refuse_state_kept: assert property (sWrite and !allowed |=> sRegsHeld and state_q == SPI_IDLE)
      else $error("refused write altered state");
endmodule : srwp_core

// *** bench/srwp_host.sv ***
`timescale 1ns/10ps
// ****************************************
// SPI host model, mode 0, status commands
// ****************************************
module srwp_host
   import srwp_pkg::*;
(
   input wire logic clock,
   input wire logic miso,
   output logic csB,
   output logic sck,
   output logic mosi
);
   // Idle: deselected, clock parked low between frames
   initial begin
      csB = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end

   // Wait n system clocks, then step just off the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_clk

   // One frame, bytes MSB first; rx keeps the last 8 bits seen on miso
   task automatic send(input logic [7:0] q[$], output logic [7:0] rx);
      rx = 8'h00;
      csB = 1'b0;
      foreach (q[i]) begin
         for (int k = 7; k >= 0; k--) begin
            mosi = q[i][k];
            wait_clk(4);
            sck = 1'b1;
            rx = {rx[6:0], miso};
            wait_clk(4);
            sck = 1'b0;
         end
      end
      wait_clk(4);
      csB = 1'b1;
      mosi = ~mosi; // Released line shows no stale bit
      wait_clk(6); // Gap above the 4-clock minimum
   endtask : send
endmodule : srwp_host

// *** bench/status_reg_write_protect_bench.sv ***
`timescale 1ns/10ps
// ****************************************
// Bench with integer model of the protection
// ****************************************
module status_reg_write_protect_bench
   import srwp_pkg::*;
;
   logic clock;
   logic rstB;
   logic wpB;
   logic holdRstB;
   logic [1:0] nvProtect;
   logic nvLock;
   logic csB, sck, mosi, miso, misoOe_b, holdActive, pinReset;
   logic [7:0] statusOne, statusTwo, statusThree, rx;
   srwp_pins_t pins;
   int errTotal = 0;
   int nChecks = 0;
   int pair, write_enable_latch, qe, sr3;
   int oeLow = 0;
   int oeBase;

   // Clock and pin bundle
   always #25 clock = ~clock;

   // Count cycles in which miso is driven
   always @(posedge clock) begin
      if (misoOe_b === 1'b0) oeLow++;
   end
   assign pins = '{csB, sck, mosi, wpB, holdRstB};

   srwp_host i_host(.clock(clock), .miso(miso), .csB(csB), .sck(sck), .mosi(mosi));
   srwp_core i_dut(.clock(clock), .rst_b(rstB), .pins(pins), .nvProtect(nvProtect), .nvLock(nvLock),
      .miso(miso), .misoOe_b(misoOe_b), .holdActive(holdActive), .pinReset(pinReset),
      .statusOne(statusOne), .statusTwo(statusTwo), .statusThree(statusThree));

   // Verdict and end of run
   task automatic conclude;
      $display("checks %0d errors %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic checkAll;
      chk({6'h00, statusTwo[0], statusOne[7]}, 8'(pair), "protect pair");
      chk({7'h00, statusOne[1]}, 8'(write_enable_latch), "write latch");
      chk({7'h00, statusTwo[1]}, 8'(qe), "quad enable");
      chk(statusThree, 8'(sr3), "register three");
   endtask : checkAll

   // Pair loaded from the non-volatile copy
   function automatic int mapNv(input int nv, input int lk);
      case (nv)
         0: return 0;
         1: return 1;
         2: return 0;
         default: return lk ? 3 : 1;
      endcase
   endfunction : mapNv

   task automatic cmd(input logic [7:0] q[$]);
      i_host.send(q, rx);
   endtask : cmd

   task automatic wren;
      cmd('{CMD_WR_ENABLE});
      write_enable_latch = 1;
   endtask : wren

   // Write with model update only when protection allows it
   task automatic writeReg(input logic [7:0] op, input logic [7:0] v);
      logic ok;
      ok = write_enable_latch == 1 && (pair == 0 || (pair == 1 && (wpB === 1'b1 || qe == 1)));
      if (op == CMD_WR_INDEXED) cmd('{op, REG_IDX_SR3, v});
      else cmd('{op, v});
      if (ok) begin
         write_enable_latch = 0;
         if (op == CMD_WR_SR2) begin
            pair = 2 * int'(v[0]) + pair % 2;
            qe = int'(v[1]);
         end else if (op == CMD_WR_SR1) pair = (pair & 2) | int'(v[7]);
         else sr3 = int'(v & 8'h80);
      end
   endtask : writeReg

   task automatic hwReset(input int nv, input int lk);
      nvProtect = nv[1:0];
      nvLock = lk[0];
      rstB = 1'b0;
      i_host.wait_clk(10);
      rstB = 1'b1;
      i_host.wait_clk(8);
      pair = mapNv(nv, lk);
      write_enable_latch = 0;
      qe = 0;
      sr3 = 0;
   endtask : hwReset

   // Main sequence: every copy value, then writes under each protection
   initial begin
      clock = 1'b0;
      rstB = 1'b0;
      wpB = 1'b1;
      holdRstB = 1'b1;
      void'($urandom(32'h47DE90BD));
      for (int c = 0; c < 5; c++) begin
         hwReset(c < 4 ? c : 3, c == 4);
         checkAll();
         if (c == 0) begin
            wren();
            writeReg(CMD_WR_SR3, 8'h80);
            holdRstB = 1'b0;
            i_host.wait_clk(8);
            chk({6'h00, pinReset, holdActive}, 8'h02, "pin role reset");
            holdRstB = 1'b1;
            i_host.wait_clk(8);
            write_enable_latch = 0;
            checkAll();
            wren();
            writeReg(CMD_WR_SR2, 8'h02);
            holdRstB = 1'b0;
            i_host.wait_clk(8);
            chk({6'h00, pinReset, holdActive}, 8'h00, "pin role with quad");
            holdRstB = 1'b1;
            i_host.wait_clk(4);
            oeBase = oeLow;
            cmd('{CMD_RD_SR3, 8'h00});
            chk(rx, 8'(sr3), "read back");
            chk({7'h00, oeLow > oeBase}, 8'h01, "read drove miso");
            chk({7'h00, misoOe_b}, 8'h01, "miso released");
            cmd('{CMD_RD_SR1, 8'h00});
            chk(rx, 8'(128 * (pair % 2) + 2 * write_enable_latch), "read one");
            cmd('{CMD_RD_SR2, 8'h00});
            chk(rx, 8'(2 * qe + pair / 2), "read two");
            wren();
            writeReg(CMD_WR_SR2, 8'h01);
            wren();
            writeReg(CMD_WR_SR3, 8'h00);
            checkAll();
            cmd('{CMD_SOFT_RESET});
            i_host.wait_clk(8);
            pair = mapNv(0, 0);
            write_enable_latch = 0;
            checkAll();
            wren();
            cmd('{CMD_WR_DISABLE});
            write_enable_latch = 0;
            writeReg(CMD_WR_SR1, 8'h80);
            checkAll();
            wren();
            writeReg(CMD_WR_SR1, 8'h80);
            checkAll();
         end
         for (int k = 0; k < 4; k++) begin
            wpB = k[1];
            i_host.wait_clk(4);
            if (k > 0) wren();
            writeReg(k[0] ? CMD_WR_INDEXED : CMD_WR_SR3, 8'($urandom));
            checkAll();
         end
         // Pair 11 unlocked in operation, then released by soft reset
         if (c == 3) begin
            wren();
            writeReg(CMD_WR_SR2, 8'h01);
            wren();
            writeReg(CMD_WR_SR3, 8'(~sr3));
            checkAll();
            cmd('{CMD_SOFT_RESET});
            i_host.wait_clk(8);
            pair = mapNv(3, 0);
            write_enable_latch = 0;
            checkAll();
         end
      end
      conclude();
   end

   // Watchdog against a hung run
   initial begin
      #2000000;
      errTotal++;
      conclude();
   end
endmodule : status_reg_write_protect_bench
